// file: rtl/adc_clock_divider.sv
// Converter clock enable divider, divide by a power of two
`timescale 1ns/1ps
module adc_clock_divider
   import adc_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic [CLKSEL_W-1:0] divSelect,
   output logic tick
);
   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] next_count;
   logic next_tick;
   logic [DIV_W-1:0] limit;

   always_comb begin
      // divide by two to the code
      limit = DIV_W'((DIV_ONE << divSelect) - DIV_ONE);
      next_count = count;
      next_tick = 1'b0;
      if (clear) begin
         next_count = '0;
      end else if (count == limit) begin
         next_count = '0;
         next_tick = 1'b1;
      end else begin
         next_count = DIV_W'(count + DIV_ONE);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule : adc_clock_divider

// file: rtl/adc_seq_pkg.sv
// Constants, register map and state type for the converter sequencer
package adc_seq_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CODE_W = 12;
   localparam int SUM_W = 16;
   localparam int BYTE_W = 8;
   localparam int PINS = 4;
   localparam int DIV_W = 7;
   localparam int PHASE_W = 4;
   localparam int COUNT_W = 4;
   localparam int SRC_W = 3;
   localparam int CHAN_W = 4;
   localparam int REF_W = 2;
   localparam int CLKSEL_W = 3;
   localparam int SRCS = 4;

   localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_PIN_SHARE = 8'h1c;

   localparam int CTRL0_START = 0;
   localparam int CTRL0_POWER = 1;
   localparam int CTRL0_FORMAT = 2;
   localparam int CTRL0_ACCUM = 3;
   localparam int CTRL0_CHAN_LSB = 4;
   localparam int CTRL0_SRC_LSB = 8;
   localparam int CTRL1_CLK_LSB = 0;
   localparam int CTRL1_REF_LSB = 4;
   localparam int CTRL1_GIE = 8;
   localparam int PIN_ANALOG_LSB = 0;
   localparam int PIN_PULL_LSB = 4;
   localparam int PIN_OUT_LSB = 8;
   localparam int IRQ_DONE = 0;
   localparam int STATUS_BUSY = 0;

   localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
   localparam logic [SRC_W-1:0] SRC_RESET = 3'h0;
   localparam logic [REF_W-1:0] REF_RESET = 2'h0;
   localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 3'h0;
   localparam logic [PINS-1:0] PINS_RESET = 4'h0;

   localparam logic [CHAN_W-1:0] EXT_LAST_CHAN = 4'h3;
   localparam logic [SRC_W-1:0] SRC_SECOND_AMP = 3'h1;
   localparam logic [SRC_W-1:0] SRC_SWCAP_AMP = 3'h2;
   localparam logic [SRC_W-1:0] SRC_FIRST_AMP = 3'h3;
   localparam logic [SRC_W-1:0] SRC_BATTERY = 3'h4;
   localparam logic [REF_W-1:0] REF_INTERNAL = 2'h1;

   localparam logic [PHASE_W-1:0] SAMPLE_LAST = 4'h3;
   localparam logic [PHASE_W-1:0] CONVERT_LAST = 4'hb;
   localparam logic [COUNT_W-1:0] ACCUM_LAST = 4'hf;
   localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b11
   } seq_state_t;
endpackage : adc_seq_pkg

// file: rtl/adc_sequencer_input_select.sv
// Converter sequencer with input selection, pin sharing and APB registers
// How it works
// - External codes 0-3 route pins 0-3
// - External codes 4-15 leave input floating
// - Source codes 1-4 pick internal signals
// - Four sample plus twelve convert cycles
// - Accumulate clear gives one conversion
// - Accumulate set sums sixteen conversions
// - Start bit low-high-low starts conversion
// - Busy high while converting, then results
// - Analog pin drops functions and pull-high
// - Analog select overrides port direction
// - Power enable low shuts converter off
// - Layout from accumulate and format bits
// - Reference code 01 picks regulator
// - Clock divide by 1 to 128
// - Completion sets request flag and interrupt
`timescale 1ns/1ps
module adc_sequencer_input_select
   import adc_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CODE_W-1:0] coreCode,
   output logic sampleEnable,
   output logic convertEnable,
   output logic converterPowerOn,
   output logic referenceInternal,
   output logic [PINS-1:0] pinRoute,
   output logic [SRCS-1:0] internalRoute,
   output logic [PINS-1:0] pinDigitalEnable,
   output logic [PINS-1:0] pinPullHigh,
   output logic [PINS-1:0] pinDrive_n,
   output logic conversionBusyFlag,
   output logic irq
);
   function automatic logic isExternal(input logic [SRC_W-1:0] src);
      isExternal = !((src == SRC_SECOND_AMP) || (src == SRC_SWCAP_AMP) ||
                     (src == SRC_FIRST_AMP) || (src == SRC_BATTERY));
   endfunction : isExternal

   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFF_CTRL0, OFF_CTRL1, OFF_STATUS, OFF_RESULT_HIGH,
         OFF_RESULT_LOW, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_PIN_SHARE: begin
            isMapped = 1'b1;
         end
         default: begin
            isMapped = 1'b0;
         end
      endcase
   endfunction : isMapped

   function automatic logic [SUM_W-1:0] formatResult(
      input logic accum,
      input logic fmt,
      input logic [CODE_W-1:0] code,
      input logic [SUM_W-1:0] sum
   );
      if (accum) begin
         formatResult = sum;
      end else if (fmt) begin
         formatResult = {{(SUM_W-CODE_W){1'b0}}, code};
      end else begin
         formatResult = {code, {(SUM_W-CODE_W){1'b0}}};
      end
   endfunction : formatResult

   // Software control state
   logic startBit;
   logic converterPowerEnable;
   logic resultFormatSelect;
   logic accumulateMode;
   logic [CHAN_W-1:0] externalChannelSelect;
   logic [SRC_W-1:0] inputSourceSelect;
   logic [CLKSEL_W-1:0] clockDividerSelect;
   logic [REF_W-1:0] referenceSelect;
   logic globalInterruptEnable;
   logic converterInterruptEnable;
   logic [PINS-1:0] pinShareSelect0;
   logic [PINS-1:0] pullHighEnable;
   logic [PINS-1:0] portOutput;
   logic next_startBit;
   logic next_converterPowerEnable;
   logic next_resultFormatSelect;
   logic next_accumulateMode;
   logic [CHAN_W-1:0] next_externalChannelSelect;
   logic [SRC_W-1:0] next_inputSourceSelect;
   logic [CLKSEL_W-1:0] next_clockDividerSelect;
   logic [REF_W-1:0] next_referenceSelect;
   logic next_globalInterruptEnable;
   logic next_converterInterruptEnable;
   logic [PINS-1:0] next_pinShareSelect0;
   logic [PINS-1:0] next_pullHighEnable;
   logic [PINS-1:0] next_portOutput;
   logic [DATA_W-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   // Sequencer state
   seq_state_t state;
   seq_state_t next_state;
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] next_phase;
   logic [COUNT_W-1:0] convCount;
   logic [COUNT_W-1:0] next_convCount;
   logic [SUM_W-1:0] sum;
   logic [SUM_W-1:0] next_sum;
   logic [SUM_W-1:0] addedSum;
   logic runAccum;
   logic next_runAccum;
   logic [BYTE_W-1:0] resultHigh;
   logic [BYTE_W-1:0] resultLow;
   logic [BYTE_W-1:0] next_resultHigh;
   logic [BYTE_W-1:0] next_resultLow;
   logic irqStatus;
   logic next_irqStatus;
   logic next_busy;
   logic divClear;
   logic adcTick;

   logic apbAccess;
   logic apbWrite;
   logic ctrl0Write;
   logic irqClear;
   logic startFall;

   assign apbAccess = psel && penable && !pready;
   assign apbWrite = psel && penable && pready && pwrite && isMapped(paddr);
   assign ctrl0Write = apbWrite && (paddr == OFF_CTRL0);
   assign irqClear = apbWrite && (paddr == OFF_IRQ_STATUS) && pwdata[IRQ_DONE];
   // Start taken on the high-to-low write
   assign startFall = ctrl0Write && startBit && !pwdata[CTRL0_START] &&
                      pwdata[CTRL0_POWER];

   // Register file: answer one cycle into the access phase
   always_comb begin
      next_startBit = startBit;
      next_converterPowerEnable = converterPowerEnable;
      next_resultFormatSelect = resultFormatSelect;
      next_accumulateMode = accumulateMode;
      next_externalChannelSelect = externalChannelSelect;
      next_inputSourceSelect = inputSourceSelect;
      next_clockDividerSelect = clockDividerSelect;
      next_referenceSelect = referenceSelect;
      next_globalInterruptEnable = globalInterruptEnable;
      next_converterInterruptEnable = converterInterruptEnable;
      next_pinShareSelect0 = pinShareSelect0;
      next_pullHighEnable = pullHighEnable;
      next_portOutput = portOutput;
      next_prdata = prdata;
      next_pready = apbAccess;
      next_pslverr = apbAccess && !isMapped(paddr);
      if (apbAccess && !pwrite) begin
         next_prdata = '0;
         case (paddr)
            OFF_CTRL0: begin
               next_prdata[CTRL0_START] = startBit;
               next_prdata[CTRL0_POWER] = converterPowerEnable;
               next_prdata[CTRL0_FORMAT] = resultFormatSelect;
               next_prdata[CTRL0_ACCUM] = accumulateMode;
               next_prdata[CTRL0_CHAN_LSB +: CHAN_W] = externalChannelSelect;
               next_prdata[CTRL0_SRC_LSB +: SRC_W] = inputSourceSelect;
            end
            OFF_CTRL1: begin
               next_prdata[CTRL1_CLK_LSB +: CLKSEL_W] = clockDividerSelect;
               next_prdata[CTRL1_REF_LSB +: REF_W] = referenceSelect;
               next_prdata[CTRL1_GIE] = globalInterruptEnable;
            end
            OFF_STATUS: begin
               next_prdata[STATUS_BUSY] = conversionBusyFlag;
            end
            OFF_RESULT_HIGH: begin
               next_prdata[BYTE_W-1:0] = resultHigh;
            end
            OFF_RESULT_LOW: begin
               next_prdata[BYTE_W-1:0] = resultLow;
            end
            OFF_IRQ_STATUS: begin
               next_prdata[IRQ_DONE] = irqStatus;
            end
            OFF_IRQ_MASK: begin
               next_prdata[IRQ_DONE] = converterInterruptEnable;
            end
            OFF_PIN_SHARE: begin
               next_prdata[PIN_ANALOG_LSB +: PINS] = pinShareSelect0;
               next_prdata[PIN_PULL_LSB +: PINS] = pullHighEnable;
               next_prdata[PIN_OUT_LSB +: PINS] = portOutput;
            end
            default: begin
               next_prdata = '0;
            end
         endcase
      end
      if (ctrl0Write) begin
         next_startBit = pwdata[CTRL0_START];
         next_converterPowerEnable = pwdata[CTRL0_POWER];
         next_resultFormatSelect = pwdata[CTRL0_FORMAT];
         next_accumulateMode = pwdata[CTRL0_ACCUM];
         next_externalChannelSelect = pwdata[CTRL0_CHAN_LSB +: CHAN_W];
         next_inputSourceSelect = pwdata[CTRL0_SRC_LSB +: SRC_W];
      end
      if (apbWrite && (paddr == OFF_CTRL1)) begin
         next_clockDividerSelect = pwdata[CTRL1_CLK_LSB +: CLKSEL_W];
         next_referenceSelect = pwdata[CTRL1_REF_LSB +: REF_W];
         next_globalInterruptEnable = pwdata[CTRL1_GIE];
      end
      if (apbWrite && (paddr == OFF_IRQ_MASK)) begin
         next_converterInterruptEnable = pwdata[IRQ_DONE];
      end
      if (apbWrite && (paddr == OFF_PIN_SHARE)) begin
         next_pinShareSelect0 = pwdata[PIN_ANALOG_LSB +: PINS];
         next_pullHighEnable = pwdata[PIN_PULL_LSB +: PINS];
         next_portOutput = pwdata[PIN_OUT_LSB +: PINS];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         startBit <= 1'b0;
         converterPowerEnable <= 1'b0;
         resultFormatSelect <= 1'b0;
         accumulateMode <= 1'b0;
         externalChannelSelect <= CHAN_RESET;
         inputSourceSelect <= SRC_RESET;
         clockDividerSelect <= CLKSEL_RESET;
         referenceSelect <= REF_RESET;
         globalInterruptEnable <= 1'b0;
         converterInterruptEnable <= 1'b0;
         pinShareSelect0 <= PINS_RESET;
         pullHighEnable <= PINS_RESET;
         portOutput <= PINS_RESET;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         startBit <= next_startBit;
         converterPowerEnable <= next_converterPowerEnable;
         resultFormatSelect <= next_resultFormatSelect;
         accumulateMode <= next_accumulateMode;
         externalChannelSelect <= next_externalChannelSelect;
         inputSourceSelect <= next_inputSourceSelect;
         clockDividerSelect <= next_clockDividerSelect;
         referenceSelect <= next_referenceSelect;
         globalInterruptEnable <= next_globalInterruptEnable;
         converterInterruptEnable <= next_converterInterruptEnable;
         pinShareSelect0 <= next_pinShareSelect0;
         pullHighEnable <= next_pullHighEnable;
         portOutput <= next_portOutput;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Converter cycle enable from the divider
   adc_clock_divider u_divider (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clear(divClear),
      .divSelect(clockDividerSelect),
      .tick(adcTick)
   );

   // Conversion sequencer
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_convCount = convCount;
      next_sum = sum;
      next_runAccum = runAccum;
      next_resultHigh = resultHigh;
      next_resultLow = resultLow;
      next_busy = conversionBusyFlag;
      // Set below is applied after the clear so a completion is never lost
      next_irqStatus = irqStatus && !irqClear;
      divClear = 1'b0;
      // Twelve-bit code widened into the running sum
      addedSum = SUM_W'(sum + {{(SUM_W-CODE_W){1'b0}}, coreCode});
      if (!converterPowerEnable) begin
         next_state = ST_IDLE;
         next_busy = 1'b0;
      end else if (startFall) begin
         // Busy rises as the start pulse ends
         next_state = ST_SAMPLE;
         next_phase = '0;
         next_convCount = '0;
         next_sum = '0;
         next_runAccum = accumulateMode;
         next_busy = 1'b1;
         divClear = 1'b1;
      end else begin
         case (state)
            ST_IDLE: begin
               next_phase = '0;
            end
            ST_SAMPLE: begin
               if (adcTick) begin
                  if (phase == SAMPLE_LAST) begin
                     next_state = ST_CONVERT;
                     next_phase = '0;
                  end else begin
                     next_phase = PHASE_W'(phase + 1'b1);
                  end
               end
            end
            ST_CONVERT: begin
               if (adcTick) begin
                  if (phase != CONVERT_LAST) begin
                     next_phase = PHASE_W'(phase + 1'b1);
                  end else if (runAccum && (convCount != ACCUM_LAST)) begin
                     next_state = ST_SAMPLE;
                     next_phase = '0;
                     next_convCount = COUNT_W'(convCount + 1'b1);
                     next_sum = addedSum;
                  end else begin
                     next_state = ST_IDLE;
                     next_sum = addedSum;
                     {next_resultHigh, next_resultLow} =
                        formatResult(runAccum, resultFormatSelect, coreCode, addedSum);
                     next_busy = 1'b0;
                     next_irqStatus = 1'b1;
                  end
               end
            end
            default: begin
               next_state = ST_IDLE;
               next_busy = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         phase <= '0;
         convCount <= '0;
         sum <= '0;
         runAccum <= 1'b0;
         resultHigh <= '0;
         resultLow <= '0;
         conversionBusyFlag <= 1'b0;
         irqStatus <= 1'b0;
         sampleEnable <= 1'b0;
         convertEnable <= 1'b0;
      end else begin
         state <= next_state;
         phase <= next_phase;
         convCount <= next_convCount;
         sum <= next_sum;
         runAccum <= next_runAccum;
         resultHigh <= next_resultHigh;
         resultLow <= next_resultLow;
         conversionBusyFlag <= next_busy;
         irqStatus <= next_irqStatus;
         sampleEnable <= (next_state == ST_SAMPLE);
         convertEnable <= (next_state == ST_CONVERT);
      end
   end

   // Analog routing and pin control, registered so outputs never glitch
   logic [PINS-1:0] next_pinRoute;
   logic [SRCS-1:0] next_internalRoute;
   logic next_irq;

   always_comb begin
      next_pinRoute = '0;
      next_internalRoute = '0;
      if (isExternal(inputSourceSelect)) begin
         // Low channel codes reach a pin
         if (externalChannelSelect <= EXT_LAST_CHAN) begin
            next_pinRoute[externalChannelSelect[1:0]] = 1'b1;
         end
      end else begin
         case (inputSourceSelect)
            SRC_SECOND_AMP: next_internalRoute[0] = 1'b1;
            SRC_SWCAP_AMP: next_internalRoute[1] = 1'b1;
            SRC_FIRST_AMP: next_internalRoute[2] = 1'b1;
            SRC_BATTERY: next_internalRoute[3] = 1'b1;
            default: next_internalRoute = '0;
         endcase
      end
      // Power enable low clears every pin and internal route
      if (!converterPowerEnable) begin
         next_pinRoute = '0;
         next_internalRoute = '0;
      end
      // Both enables gate the request line
      next_irq = irqStatus && converterInterruptEnable && globalInterruptEnable;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pinRoute <= '0;
         internalRoute <= '0;
         converterPowerOn <= 1'b0;
         referenceInternal <= 1'b0;
         pinDigitalEnable <= '1;
         pinPullHigh <= '0;
         pinDrive_n <= '1;
         irq <= 1'b0;
      end else begin
         pinRoute <= next_pinRoute;
         internalRoute <= next_internalRoute;
         converterPowerOn <= converterPowerEnable;
         // Only code 01 picks the regulator
         referenceInternal <= (referenceSelect == REF_INTERNAL);
         // Analog pins lose digital use and pull-high
         pinDigitalEnable <= ~pinShareSelect0;
         pinPullHigh <= pullHighEnable & ~pinShareSelect0;
         pinDrive_n <= ~(portOutput & ~pinShareSelect0);
         irq <= next_irq;
      end
   end
endmodule : adc_sequencer_input_select

// file: sim/adc_core_model.sv
// Behavioural converter core that answers with a code for the routed input
`timescale 1ns/1ps
module adc_core_model
   import adc_seq_pkg::*;
#(
   parameter logic [CODE_W-1:0] CODE_A = 12'h5a3,
   parameter logic [CODE_W-1:0] CODE_B = 12'hfff
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [PINS-1:0] pinRoute,
   input wire logic convertEnable,
   output logic [CODE_W-1:0] coreCode
);
   logic [CODE_W-1:0] next_coreCode;
   always_comb begin
      if (!reset_n) begin
         next_coreCode = 12'h000;
      end else if (!convertEnable) begin
         // Code toggles outside conversion so a mistimed sample shows up
         next_coreCode = ~coreCode;
      end else if (pinRoute[1]) begin
         next_coreCode = CODE_B;
      end else begin
         next_coreCode = CODE_A;
      end
   end
   always_ff @(posedge ref_clk) begin
      coreCode <= next_coreCode;
   end
endmodule : adc_core_model

// file: sim/adc_sequencer_input_select_assertions.sv
// Port checks for the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_input_select_assertions
   import adc_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic sampleEnable,
   input wire logic convertEnable,
   input wire logic converterPowerOn,
   input wire logic referenceInternal,
   input wire logic [PINS-1:0] pinRoute,
   input wire logic [SRCS-1:0] internalRoute,
   input wire logic [PINS-1:0] pinDigitalEnable,
   input wire logic [PINS-1:0] pinPullHigh,
   input wire logic [PINS-1:0] pinDrive_n,
   input wire logic conversionBusyFlag
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_write(logic [ADDR_W-1:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   property p_ref;
      logic r;
      (s_write(OFF_CTRL1), r = (pwdata[CTRL1_REF_LSB +: REF_W] == REF_INTERNAL))
         |-> ##2 referenceInternal == r;
   endproperty
   a_busy_needs_start: assert property ($rose(conversionBusyFlag) |->
      $past(psel && penable && pready && pwrite && paddr == OFF_CTRL0))
      else $error("busy rose without a control write");
   a_phase_exclusive: assert property (!(sampleEnable && convertEnable))
      else $error("sample and convert phases overlap");
   a_convert_after_sample: assert property ($rose(convertEnable) |-> $past(sampleEnable))
      else $error("convert without sample");
   a_busy_while_sampling: assert property (sampleEnable |-> conversionBusyFlag)
      else $error("sampling while busy is low");
   a_pin_route_single: assert property ($onehot0(pinRoute))
      else $error("more than one pin routed");
   a_source_single: assert property ($onehot0(internalRoute))
      else $error("two internal sources routed");
   a_power_off_quiet: assert property (!converterPowerOn ##1 !converterPowerOn |->
      pinRoute == 4'h0 && internalRoute == 4'h0 && !conversionBusyFlag)
      else $error("active while powered off");
   a_pull_dropped: assert property ((pinPullHigh & ~pinDigitalEnable) == 4'h0)
      else $error("pull-high left on an analog pin");
   a_drive_overridden: assert property ((~pinDrive_n & ~pinDigitalEnable) == 4'h0)
      else $error("analog pin still driven");
   a_ref_follows_field: assert property (p_ref)
      else $error("reference not followed");
endmodule : adc_sequencer_input_select_assertions
bind adc_sequencer_input_select adc_sequencer_input_select_assertions u_chk (.ref_clk, .reset_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .sampleEnable, .convertEnable,
   .converterPowerOn, .referenceInternal, .pinRoute, .internalRoute, .pinDigitalEnable,
   .pinPullHigh, .pinDrive_n, .conversionBusyFlag);

// file: sim/adc_sequencer_input_select_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_input_select_tb;
   import adc_seq_pkg::*;
   localparam logic [CODE_W-1:0] CODE_A = 12'h5a3;
   localparam logic [CODE_W-1:0] CODE_B = 12'hfff;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h0;
   logic [DATA_W-1:0] prdata, rdata;
   logic pready, pslverr, rerr, sampleEnable, convertEnable, converterPowerOn;
   logic referenceInternal, conversionBusyFlag, irq;
   logic [PINS-1:0] pinRoute, pinDigitalEnable, pinPullHigh, pinDrive_n;
   logic [SRCS-1:0] internalRoute;
   logic [CODE_W-1:0] coreCode;
   int failures = 0;
   int checksDone = 0;
   always #2 ref_clk = ~ref_clk;
   adc_sequencer_input_select u_dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .coreCode, .sampleEnable, .convertEnable,
      .converterPowerOn, .referenceInternal, .pinRoute, .internalRoute, .pinDigitalEnable,
      .pinPullHigh, .pinDrive_n, .conversionBusyFlag, .irq);
   adc_core_model #(.CODE_A(CODE_A), .CODE_B(CODE_B)) u_core (.ref_clk, .reset_n, .pinRoute,
      .convertEnable, .coreCode);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      chk("pready wait", 32'h2, 32'(n));
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic t_reset_values;
      chk("pinDigitalEnable", 32'hf, 32'(pinDigitalEnable));
      apb(1'b0, OFF_CTRL0, 32'h0);
      chk("ctrl0 reset", 32'h0, rdata);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, 32'(rerr));
   endtask : t_reset_values
   task automatic t_routes;
      logic [PINS-1:0] ep;
      logic [SRCS-1:0] ei;
      for (int s = 0; s < 8; s++) begin
         for (int c = 0; c < 16; c++) begin
            ep = ((s == 0 || s > 4) && c < 4) ? 4'(1 << c) : 4'h0;
            ei = (s >= 1 && s <= 4) ? 4'(1 << (s - 1)) : 4'h0;
            if (ei != 4'h0 && c < 4) continue;
            apb(1'b1, OFF_CTRL0, 32'((s << CTRL0_SRC_LSB) | (c << CTRL0_CHAN_LSB) | 2));
            @(posedge ref_clk);
            chk("pinRoute", 32'(ep), 32'(pinRoute));
            chk("internalRoute", 32'(ei), 32'(internalRoute));
         end
      end
   endtask : t_routes
   task automatic t_pins;
      apb(1'b1, OFF_PIN_SHARE, 32'h00000ff5);
      @(posedge ref_clk);
      chk("pinPullHigh", 32'ha, 32'(pinPullHigh));
      chk("pinDrive_n", 32'h5, 32'(pinDrive_n));
      chk("pinDigitalEnable", 32'ha, 32'(pinDigitalEnable));
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, OFF_CTRL1, 32'(r << CTRL1_REF_LSB));
         @(posedge ref_clk);
         chk("referenceInternal", 32'(r == 1), 32'(referenceInternal));
      end
   endtask : t_pins
   task automatic conv(input logic acc, input logic fmt, input int sel, input int c,
      input logic irqExp);
      logic [SUM_W-1:0] e;
      logic [DATA_W-1:0] w;
      int n = 0, len;
      e = (acc || !fmt) ? {(c == 1 ? CODE_B : CODE_A), 4'h0} : {4'h0, (c == 1 ? CODE_B : CODE_A)};
      w = 32'((c << CTRL0_CHAN_LSB) | (acc << CTRL0_ACCUM) | (fmt << CTRL0_FORMAT) | 2);
      len = (acc ? 256 : 16) << sel;
      apb(1'b1, OFF_CTRL1, 32'(sel | (1 << CTRL1_GIE)));
      apb(1'b1, OFF_CTRL0, w | 32'h1);
      apb(1'b1, OFF_CTRL0, w);
      @(posedge ref_clk);
      chk("busy set", 32'h1, 32'(conversionBusyFlag));
      while (conversionBusyFlag !== 1'b0) begin
         @(posedge ref_clk);
         n++;
      end
      chk("busy length", 32'h1, 32'(n >= len - 2 && n <= len + 1));
      apb(1'b0, OFF_RESULT_HIGH, 32'h0);
      chk("result_high", 32'(e[15:8]), rdata);
      apb(1'b0, OFF_RESULT_LOW, 32'h0);
      chk("result_low", 32'(e[7:0]), rdata);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      chk("irq status", 32'h1, rdata);
      chk("irq", 32'(irqExp), 32'(irq));
      apb(1'b1, OFF_IRQ_STATUS, 32'h1);
      @(posedge ref_clk);
      chk("irq cleared", 32'h0, 32'(irq));
   endtask : conv
   task automatic t_abort;
      apb(1'b1, OFF_CTRL1, 32'h7);
      apb(1'b1, OFF_CTRL0, 32'h3);
      apb(1'b1, OFF_CTRL0, 32'h2);
      repeat (100) @(posedge ref_clk);
      apb(1'b1, OFF_CTRL0, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk("busy off", 32'h0, 32'(conversionBusyFlag));
      chk("route off", 32'h0, 32'(pinRoute));
      chk("power on", 32'h0, 32'(converterPowerOn));
      apb(1'b1, OFF_CTRL0, 32'h1);
      apb(1'b1, OFF_CTRL0, 32'h0);
      repeat (2100) @(posedge ref_clk);
      chk("start refused", 32'h0, 32'(conversionBusyFlag));
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      chk("no done", 32'h0, rdata);
   endtask : t_abort
   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset_values;
      t_routes;
      t_pins;
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      for (int s = 0; s < 8; s++) conv(1'b0, 1'b1, s, 1, 1'b1);
      conv(1'b0, 1'b0, 0, 1, 1'b1);
      conv(1'b1, 1'b1, 0, 0, 1'b1);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      conv(1'b0, 1'b0, 1, 2, 1'b0);
      t_abort;
      stop_test;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      stop_test;
   end
endmodule : adc_sequencer_input_select_tb
